// [include/cpd_pkg.sv]
// constants for the configuration prom data port
package cpd_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // revision start addresses, count limit reset value
  localparam logic [15:0] REV0_START = 16'h0000;
  localparam logic [15:0] REV1_START = 16'h4000;
  localparam logic [15:0] REV2_START = 16'h8000;
  localparam logic [15:0] REV3_START = 16'hc000;
  localparam logic [15:0] COUNT_LIMIT_RST = 16'hffff;
  // ==========================================================
  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // internal oscillator divide (half period in ns, converted to clk cycles)
  localparam int OSC_HALF_NS = 40;
  localparam int CLK_NS = 10;
  localparam int OSC_HALF_CYC = (OSC_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] OSC_HALF_CNT = 4'(OSC_HALF_CYC - 1);
endpackage : cpd_pkg

// [src/cpd_fifo.sv]
// small valid/ready fifo for the data path
`timescale 1ns/1ps
module cpd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // control
  input  wire logic             flush_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cpd_fifo

// [src/cpd_port.sv]
// configuration prom output port: counter, stall, clock out, cascade
`timescale 1ns/1ps
module cpd_port (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // pins from the far side (asynchronous)
  input  wire logic        link_clk_i,
  input  wire logic        chip_enable_n_i,
  input  wire logic        oe_reset_n_i,
  input  wire logic        busy_i,
  input  wire logic        config_pulse_n_i,
  input  wire logic        external_revision_choose_n_i,
  input  wire logic        revision_pick_bit0_i,
  input  wire logic        revision_pick_bit1_i,
  // stored programming bits
  input  wire logic        parallel_mode_i,
  input  wire logic        decompress_i,
  input  wire logic        clock_out_enable_i,
  input  wire logic        use_osc_i,
  input  wire logic [1:0]  stored_revision_i,
  input  wire logic [15:0] count_limit_i,
  // memory read side
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  input  wire logic        mem_ready_i,
  // pins to the far side
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  output logic             config_clock_out_o,
  output logic             config_clock_out_oe_o,
  output logic             cascade_enable_out_n_o
);
  // ==========================================================
  // synchronisers
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       lclk_d_reg;
  logic       cfg_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 6'h3c;
      sync2_reg <= 6'h3c;
    end else begin
      // pull-down on stall reads 0 when undriven (pin model)
      sync1_reg <= {config_pulse_n_i, external_revision_choose_n_i, oe_reset_n_i,
                    chip_enable_n_i, busy_i, link_clk_i};
      sync2_reg <= sync1_reg;
    end
  end
  logic lclk_s, busy_s, ce_n_s, oe_s, ext_n_s, cfg_s;
  assign lclk_s  = sync2_reg[0];
  assign busy_s  = sync2_reg[1];
  assign ce_n_s  = sync2_reg[2];
  assign oe_s    = sync2_reg[3];
  assign ext_n_s = sync2_reg[4];
  assign cfg_s   = sync2_reg[5];

  // revision pins are static straps, sampled via two flops too
  logic [1:0] rev1_reg;
  logic [1:0] rev2_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev1_reg <= 2'h0;
      rev2_reg <= 2'h0;
    end else begin
      rev1_reg <= {revision_pick_bit1_i, revision_pick_bit0_i};
      rev2_reg <= rev1_reg;
    end
  end

  // ==========================================================
  // internal oscillator
  logic [3:0] osc_cnt_reg;
  logic       osc_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_reg <= 4'h0;
      osc_reg     <= 1'b0;
    end else if (osc_cnt_reg == cpd_pkg::OSC_HALF_CNT) begin
      osc_cnt_reg <= 4'h0;
      osc_reg     <= ~osc_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  // ==========================================================
  // edge detection of selected source
  logic src_rise;
  logic src_fall;
  logic cfg_rise;
  logic osc_d_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lclk_d_reg <= 1'b0;
      osc_d_reg  <= 1'b0;
      cfg_d_reg  <= 1'b1;
    end else begin
      lclk_d_reg <= lclk_s;
      osc_d_reg  <= osc_reg;
      cfg_d_reg  <= cfg_s;
    end
  end
  assign src_rise = use_osc_i ? (osc_reg && !osc_d_reg) : (lclk_s && !lclk_d_reg);
  assign src_fall = use_osc_i ? (!osc_reg && osc_d_reg) : (!lclk_s && lclk_d_reg);
  assign cfg_rise = cfg_s && !cfg_d_reg;

  // ==========================================================
  // stall qualification
  logic stall;
  assign stall = parallel_mode_i && !decompress_i && busy_s;

  // ==========================================================
  // revision start address
  function automatic logic [15:0] rev_start(input logic [1:0] r);
    unique case (r)
      2'h0: rev_start = cpd_pkg::REV0_START;
      2'h1: rev_start = cpd_pkg::REV1_START;
      2'h2: rev_start = cpd_pkg::REV2_START;
      2'h3: rev_start = cpd_pkg::REV3_START;
    endcase
  endfunction : rev_start
  logic [1:0] rev_sel;
  assign rev_sel = ext_n_s ? stored_revision_i : rev2_reg;
  logic [15:0] rev_addr;
  assign rev_addr = rev_start(rev_sel);

  // ==========================================================
  // address counter feeding the fifo
  logic        active;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        take;
  logic        past_limit_reg;
  logic [15:0] addr_reg;
  assign active = !ce_n_s && oe_s;

  always_ff @(posedge clk_i) begin
    if (rst_i || ce_n_s || !oe_s) begin
      addr_reg       <= cpd_pkg::ADDR_RST;
      past_limit_reg <= 1'b0;
    end else if (cfg_rise) begin
      addr_reg       <= rev_addr;
      past_limit_reg <= 1'b0;
    end else if (mem_ready_i && fifo_in_ready) begin
      addr_reg <= addr_reg + 16'h1;
      if (addr_reg == count_limit_i) begin
        past_limit_reg <= 1'b1;
      end
    end
  end
  assign mem_addr_o = addr_reg;

  cpd_fifo #(
    .WIDTH (cpd_pkg::DATA_W),
    .DEPTH (cpd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (active && mem_ready_i && !cfg_rise),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_data_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (take),
    .out_data_o  (fifo_out_data),
    .flush_i     (!active || cfg_rise)
  );

  // advance on source rise when data available and not stalled
  // no take while parked high or reloading: the word would go out with no clock edge
  assign take = active && src_rise && fifo_out_valid && !stall
                && !cfg_rise && !config_clock_out_o;

  // ==========================================================
  // output pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= active;
      if (take) begin
        data_o <= fifo_out_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_clock_out_o    <= 1'b1;
      config_clock_out_oe_o <= 1'b0;
    end else begin
      config_clock_out_oe_o <= active && clock_out_enable_i;
      if (decompress_i && !fifo_out_valid) begin
        config_clock_out_o <= 1'b1;
      end else if (take) begin
        // outside decompress mode rises only with a fresh word, so gaps appear while stalled or empty
        config_clock_out_o <= 1'b1;
      end else if (src_fall) begin
        config_clock_out_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cascade_enable_out_n_o <= 1'b1;
    end else begin
      cascade_enable_out_n_o <= !(active && past_limit_reg);
    end
  end

  // ==========================================================
  // checks
  a_stall_holds_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (stall && $stable(data_oe_o)) |=> $stable(data_o))
    else $error("data changed while stalled");
  a_clk_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_n_s || !oe_s) |=> !config_clock_out_oe_o)
    else $error("clock out driven while deselected");
  a_clk_enable_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    !clock_out_enable_i |=> !config_clock_out_oe_o)
    else $error("clock out driven without enable");
  a_cascade_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_n_s |=> cascade_enable_out_n_o)
    else $error("cascade low while deselected");
  a_standby_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_n_s |=> (addr_reg == cpd_pkg::ADDR_RST) && !data_oe_o)
    else $error("standby did not reset");
  a_decomp_park: assert property (@(posedge clk_i) disable iff (rst_i)
    (decompress_i && !fifo_out_valid) |=> config_clock_out_o)
    else $error("clock out not parked high");
  a_serial_no_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    ((!parallel_mode_i || decompress_i) && busy_s && active && src_rise && fifo_out_valid
     && !cfg_rise && !config_clock_out_o) |=> (data_o == $past(fifo_out_data)))
    else $error("stall honoured outside parallel");
  a_reload_rev: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_rise && active) |=> (addr_reg == $past(rev_addr)))
    else $error("revision start not loaded");
  a_rise_with_word: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> (config_clock_out_o && (data_o == $past(fifo_out_data))))
    else $error("clock out rose without its word");
endmodule : cpd_port

// [verif/cpd_fpga_model.sv]
// far-side logic model: link clock, stall and word capture
`timescale 1ns/1ps
module cpd_fpga_model (
  // clock
  input  wire logic       clk_i,
  // bench control
  input  wire logic       run_i,
  input  wire logic       hold_i,
  // pins
  input  wire logic [7:0] data_i,
  input  wire logic       den_i,
  input  wire logic       cclk_i,
  output logic            link_clk_o,
  output logic            busy_o,
  // captured words
  output logic [7:0]      last_o,
  output int              cnt_o
);
  // ========================================
  // link clock, still between frames
  logic cclk_q = 1'b1;
  int   n      = 0;
  initial begin
    link_clk_o = 1'b0;
    #3;
    forever begin
      #40;
      link_clk_o = run_i ? ~link_clk_o : 1'b0;
    end
  end
  assign busy_o = hold_i;
  assign cnt_o  = n;
  // take a word on each rise of the clock out
  always @(posedge clk_i) begin
    cclk_q <= cclk_i;
    if (cclk_i && !cclk_q && den_i) begin
      last_o <= data_i;
      n      <= n + 1;
    end
  end
endmodule : cpd_fpga_model

// [verif/testbench.sv]
// self-checking bench for the prom output port
`timescale 1ns/1ps
module testbench;
  // ========================================
  // stimulus and wires
  logic clk = 1'b0, rst = 1'b1, ce_n = 1'b1, oe_n = 1'b1, cp_n = 1'b1;
  logic ext_n = 1'b1, rp0 = 1'b0, rp1 = 1'b0, par = 1'b1, dec = 1'b0;
  logic osc = 1'b0, rdy = 1'b1, run = 1'b0, hold = 1'b0, cke = 1'b1;
  logic [1:0]  srev = 2'h0;
  logic [15:0] lim  = 16'hffff, addr;
  logic [7:0]  dout, last, a, b;
  logic doe, cko, ckoe, cas_n, link, busy, cpin;
  int   cnt, err_total = 0, comparisons = 0, cyc = 0;
  assign cpin = ckoe ? cko : 1'b1;
  cpd_port dut_u (.clk_i(clk), .rst_i(rst), .link_clk_i(link), .chip_enable_n_i(ce_n),
    .oe_reset_n_i(oe_n), .busy_i(busy), .config_pulse_n_i(cp_n),
    .external_revision_choose_n_i(ext_n), .revision_pick_bit0_i(rp0),
    .revision_pick_bit1_i(rp1), .parallel_mode_i(par), .decompress_i(dec),
    .clock_out_enable_i(cke), .use_osc_i(osc), .stored_revision_i(srev),
    .count_limit_i(lim), .mem_addr_o(addr), .mem_data_i({addr[15:14], addr[5:0]}),
    .mem_ready_i(rdy), .data_o(dout), .data_oe_o(doe), .config_clock_out_o(cko),
    .config_clock_out_oe_o(ckoe), .cascade_enable_out_n_o(cas_n));
  cpd_fpga_model fpga_u (.clk_i(clk), .run_i(run), .hold_i(hold), .data_i(dout),
    .den_i(doe), .cclk_i(cpin), .link_clk_o(link), .busy_o(busy), .last_o(last),
    .cnt_o(cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  // ========================================
  // shared tasks
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic word(output logic [7:0] w);
    int c0;
    c0 = cnt;
    for (int i = 0; i < 300 && cnt == c0; i++) begin
      @(posedge clk);
    end
    chk("word arrives", 1, cnt != c0);
    w = last;
  endtask : word
  task automatic step(input string what);
    word(b);
    chk(what, {a[7:6], a[5:0] + 6'h01}, b);
    a = b;
  endtask : step
  // deselect, check idle pins, then reload and run
  task automatic restart();
    @(posedge clk);
    ce_n <= 1'b1;
    run  <= 1'b0;
    repeat (8) @(posedge clk);
    chk("data oe idle", 0, doe);
    chk("clock oe idle", 0, ckoe);
    chk("cascade idle", 1, cas_n);
    ce_n <= 1'b0;
    cp_n <= 1'b0;
    repeat (3) @(posedge clk);
    cp_n <= 1'b1;
    // let the reload and refill finish first, or the first word is a stale one
    repeat (8) @(posedge clk);
    run  <= 1'b1;
  endtask : restart
  // ========================================
  // scenarios
  task automatic t_stream();
    restart();
    word(a);
    chk("clock oe on", 1, ckoe);
    chk("cascade high", 1, cas_n);
    for (int i = 0; i < 5; i++) step("word order");
    oe_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("clock oe reset", 0, ckoe);
    oe_n <= 1'b1;
    cke  <= 1'b0;
    repeat (6) @(posedge clk);
    chk("clock oe off", 0, ckoe);
    cke  <= 1'b1;
    $display("stream done");
  endtask : t_stream
  task automatic t_stall();
    int c;
    restart();
    word(a);
    hold <= 1'b1;
    repeat (30) @(posedge clk);
    c = cnt;
    a = dout;
    repeat (60) @(posedge clk);
    chk("count frozen", c[15:0], cnt[15:0]);
    chk("data held", a, dout);
    hold <= 1'b0;
    step("after stall");
    $display("stall done");
  endtask : t_stall
  task automatic t_ignore();
    for (int k = 0; k < 2; k++) begin
      par  <= k[0];
      dec  <= k[0];
      restart();
      hold <= 1'b1;
      word(a);
      step("stall ignored");
      hold <= 1'b0;
    end
    par <= 1'b1;
    dec <= 1'b0;
    $display("ignore done");
  endtask : t_ignore
  task automatic t_osc_park();
    osc <= 1'b1;
    restart();
    run <= 1'b0;
    word(a);
    step("osc source");
    osc <= 1'b0;
    dec <= 1'b1;
    rdy <= 1'b0;
    restart();
    repeat (40) @(posedge clk);
    chk("clock parked", 1, cko);
    dec <= 1'b0;
    rdy <= 1'b1;
    $display("osc park done");
  endtask : t_osc_park
  task automatic t_rev();
    logic [1:0] r;
    for (int k = 0; k < 8; k++) begin
      r = k[1:0];
      ext_n <= k[2];
      {rp1, rp0} <= k[2] ? ~r : r;
      srev  <= k[2] ? r : ~r;
      restart();
      word(a);
      chk("revision", r, a[7:6]);
    end
    ext_n <= 1'b1;
    srev  <= 2'h0;
    lim   <= 16'h0003;
    restart();
    for (int i = 0; i < 8; i++) word(a);
    chk("cascade low", 0, cas_n);
    lim <= 16'hffff;
    $display("revision done");
  endtask : t_rev
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_stream();
    t_stall();
    t_ignore();
    t_osc_park();
    t_rev();
    end_of_test();
  end
endmodule : testbench
